// ### logic/ettm_pkg.sv
// Constants for the 10-bit up-counting timer with three comparators.
// Assumes a single 50 MHz clock and an AXI4-Lite register port.
`default_nettype none
package ettm_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CNT_W         = 10;
  localparam int unsigned PER_W         = 3;
  localparam int unsigned PER_LSB       = 7;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL0      = 8'h00;
  localparam logic [7:0] OFS_CTRL1      = 8'h04;
  localparam logic [7:0] OFS_CTRL2      = 8'h08;
  localparam logic [7:0] OFS_CNT_LO     = 8'h0C;
  localparam logic [7:0] OFS_CNT_HI     = 8'h10;
  localparam logic [7:0] OFS_CMPA_LO    = 8'h14;
  localparam logic [7:0] OFS_CMPA_HI    = 8'h18;
  localparam logic [7:0] OFS_CMPB_LO    = 8'h1C;
  localparam logic [7:0] OFS_CMPB_HI    = 8'h20;
  // Reset values
  localparam logic [7:0] CTRL0_RST      = 8'h00;
  localparam logic [7:0] CTRL1_RST      = 8'h00;
  localparam logic [7:0] CTRL2_RST      = 8'h00;
  localparam logic [9:0] CMP_RST        = 10'h000;
  // Control 0 fields
  localparam int unsigned C0_PAUSE      = 7;
  localparam int unsigned C0_CKS_LSB    = 4;
  localparam int unsigned C0_ON         = 3;
  localparam int unsigned C0_PER_LSB    = 0;
  // Control 1 fields
  localparam int unsigned C1_MODE_LSB   = 6;
  localparam int unsigned C1_FUNC_LSB   = 4;
  localparam int unsigned C1_OCTL       = 3;
  localparam int unsigned C1_POL        = 2;
  localparam int unsigned C1_DIR        = 1;
  localparam int unsigned C1_CCLR       = 0;
  // Prescaler widths
  localparam int unsigned DIV4_W        = 2;
  localparam int unsigned HDIV_W        = 6;
  localparam logic [3:0] HDIV16_MASK    = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    ETTM_MODE_CMP  = 2'b00,
    ETTM_MODE_CAP  = 2'b01,
    ETTM_MODE_PWM  = 2'b10,
    ETTM_MODE_TMR  = 2'b11
  } ettm_mode_t;

  typedef enum logic [2:0] {
    ETTM_CK_SYS4   = 3'b000,
    ETTM_CK_SYS    = 3'b001,
    ETTM_CK_H16    = 3'b010,
    ETTM_CK_H64    = 3'b011,
    ETTM_CK_TBC    = 3'b100,
    ETTM_CK_RSVD   = 3'b101,
    ETTM_CK_EXTR   = 3'b110,
    ETTM_CK_EXTF   = 3'b111
  } ettm_cks_t;
endpackage
`default_nettype wire

// ### logic/ettm_top.sv
// 10-bit up-counting timer with compare A/B, period P, capture and PWM on pin A.
// Assumes clock-synchronous inputs and ticks, and an AXI4-Lite master.
// Function
// R1: 10-bit counter, internal or external clock
// R2: A,B full compare; P on top bits
// R3: Software clears counter only via on rising
// R4: Overflow or match clears counter, raises event
// R5: Pause bit holds counter, resume afterwards
// R6: 3-bit clock source select, 101 stops
// R7: On rising clears counter, falling stops, keeps
// R8: Compare mode: on rising restores initial level
// R9: Period match every 128 times value
// R10: Clear select 0: P match clears counter; the code does not clear on P match in single pulse mode
// R11: Channel A mode field decode
// R12: Software turns off before mode changes
// R13: Compare mode A match: none/low/high/toggle
// R14: PWM mode: inactive/active/PWM/single pulse
// R15: Capture edge: rise/fall/both/disabled
// R16: Counter read-only pair, compare pairs RW
// R17: Direction flag reads 0 when counting up
// R18: Clear select 1: A match clears counter; the code clears on A match in compare and timer modes only
// R19: Output control sets active level
// R20: Polarity bit inverts pin A
// R21: External clock synchronised, one count per edge
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ettm_top
  import ettm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // Internal clock ticks
  input  wire logic                   high_clock_tick,
  input  wire logic                   time_base_tick,
  // Pins
  input  wire logic                   external_clock_pin,
  input  wire logic                   pin_a_in,
  output var  logic                   output_pin_a,
  output var  logic                   output_pin_a_oe,
  // Events
  output var  logic                   event_a,
  output var  logic                   event_b,
  output var  logic                   event_p,
  // AXI4-Lite write
  input  wire logic [ettm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [ettm_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ettm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [ettm_pkg::DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import ettm_pkg::*;

  // Register state
  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [7:0]       ctrl2_reg;
  logic [9:0]       cmpa_reg;
  logic [9:0]       cmpb_reg;
  logic [9:0]       cnt_reg;
  logic             on_dly_reg;
  logic             level_reg;
  logic [DIV4_W-1:0] div4_reg;
  logic [HDIV_W-1:0] hdiv_reg;
  logic [2:0]       ext_sync_reg;
  logic [1:0]       pin_sync_reg;
  // Bus state
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] araddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             aw_have_reg;
  logic             w_have_reg;
  logic             ar_have_reg;

  // Field decode
  wire              pause_bit   = ctrl0_reg[C0_PAUSE];
  wire ettm_cks_t   cks         = ettm_cks_t'(ctrl0_reg[C0_CKS_LSB +: 3]);
  wire              on_bit      = ctrl0_reg[C0_ON];
  wire [PER_W-1:0]  per_val     = ctrl0_reg[C0_PER_LSB +: PER_W];
  wire ettm_mode_t  mode        = ettm_mode_t'(ctrl1_reg[C1_MODE_LSB +: 2]);
  wire [1:0]        func        = ctrl1_reg[C1_FUNC_LSB +: 2];
  wire              octl        = ctrl1_reg[C1_OCTL];
  wire              pol         = ctrl1_reg[C1_POL];
  wire              cclr        = ctrl1_reg[C1_CCLR];
  wire              is_cmp      = (mode == ETTM_MODE_CMP); // R11
  wire              is_cap      = (mode == ETTM_MODE_CAP); // R11
  wire              is_pwm      = (mode == ETTM_MODE_PWM); // R11
  wire              is_tmr      = (mode == ETTM_MODE_TMR); // R11
  wire              is_single   = is_pwm && (func == 2'b11);

  // Clock source selection
  wire              div4_tick   = (div4_reg == '0);
  wire              h16_tick    = high_clock_tick &&
                                  (hdiv_reg[3:0] == HDIV16_MASK);
  wire              h64_tick    = high_clock_tick && (&hdiv_reg);
  wire              ext_rise    = ext_sync_reg[1] && !ext_sync_reg[2]; // R21
  wire              ext_fall    = !ext_sync_reg[1] && ext_sync_reg[2]; // R21
  logic             src_tick;
  always_comb begin
    case (cks) // R6
      ETTM_CK_SYS4: src_tick = div4_tick;
      ETTM_CK_SYS:  src_tick = 1'b1;
      ETTM_CK_H16:  src_tick = h16_tick;
      ETTM_CK_H64:  src_tick = h64_tick;
      ETTM_CK_TBC:  src_tick = time_base_tick;
      ETTM_CK_EXTR: src_tick = ext_rise; // R1
      ETTM_CK_EXTF: src_tick = ext_fall; // R1
      default:      src_tick = 1'b0;
    endcase
  end

  // Count and comparators
  wire              on_rise     = on_bit && !on_dly_reg; // R7
  wire              run         = on_bit && on_dly_reg && !pause_bit; // R5
  wire              tick        = run && src_tick;
  wire [9:0]        cnt_inc     = cnt_reg + 10'h001;
  wire              a_hit       = tick && (cnt_inc == cmpa_reg); // R2
  wire              b_hit       = tick && (cnt_inc == cmpb_reg); // R2
  wire              p_hit       = tick &&
                                  (cnt_inc[CNT_W-1:PER_LSB] == per_val) &&
                                  (cnt_inc[PER_LSB-1:0] == '0); // R9
  wire              a_clears    = (is_cmp || is_tmr) && cclr; // R18
  wire              p_clears    = !is_single && !a_clears; // R10
  wire              p_event     = p_hit && !is_single && !a_clears;

  logic [9:0]       cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (on_rise) begin
      cnt_next = '0; // R3
    end else if (tick) begin
      if ((a_hit && a_clears) || (p_hit && p_clears)) begin
        cnt_next = '0; // R4
      end else begin
        cnt_next = cnt_inc; // R1
      end
    end
  end

  // Capture edges on pin A
  wire              pin_rise    = pin_sync_reg[0] && !pin_sync_reg[1];
  wire              pin_fall    = !pin_sync_reg[0] && pin_sync_reg[1];
  logic             cap_hit;
  always_comb begin
    case (func) // R15
      2'b00:   cap_hit = pin_rise;
      2'b01:   cap_hit = pin_fall;
      2'b10:   cap_hit = pin_rise || pin_fall;
      default: cap_hit = 1'b0;
    endcase
  end
  wire              capture     = is_cap && on_bit && cap_hit;

  // Output level before polarity
  wire              active_lvl  = octl; // R19
  logic             level_next;
  always_comb begin
    level_next = level_reg;
    if (is_cmp) begin
      if (on_rise) begin
        level_next = octl; // R8
      end else if (a_hit) begin
        case (func) // R13
          2'b01:   level_next = 1'b0;
          2'b10:   level_next = 1'b1;
          2'b11:   level_next = !level_reg;
          default: level_next = level_reg;
        endcase
      end
    end else if (is_pwm) begin
      case (func) // R14
        2'b00:   level_next = !active_lvl;
        2'b01:   level_next = active_lvl;
        2'b10:   level_next = (cnt_next < cmpa_reg) ? active_lvl
                                                    : !active_lvl;
        default: level_next = (on_bit && !a_hit) ? active_lvl
                                                 : !active_lvl;
      endcase
    end
  end

  // Bus decode
  wire              wr_go       = aw_have_reg && w_have_reg &&
                                  !s_axi_bvalid;
  wire              wr_lane0    = wr_go && wstrb_reg[0];
  wire              wr_lane1    = wr_go && wstrb_reg[1];
  wire [7:0]        wb0         = wdata_reg[7:0];
  wire [1:0]        wb1         = wdata_reg[1:0];
  wire              wr_c0       = wr_lane0 && (awaddr_reg == OFS_CTRL0);
  wire              wr_c1       = wr_lane0 && (awaddr_reg == OFS_CTRL1);
  wire              wr_c2       = wr_lane0 && (awaddr_reg == OFS_CTRL2);
  wire              wr_al       = wr_lane0 && (awaddr_reg == OFS_CMPA_LO);
  wire              wr_ah       = wr_lane0 && (awaddr_reg == OFS_CMPA_HI);
  wire              wr_bl       = wr_lane0 && (awaddr_reg == OFS_CMPB_LO);
  wire              wr_bh       = wr_lane0 && (awaddr_reg == OFS_CMPB_HI);
  wire              wr_mapped   = (awaddr_reg == OFS_CTRL0) ||
                                  (awaddr_reg == OFS_CTRL1) ||
                                  (awaddr_reg == OFS_CTRL2) ||
                                  (awaddr_reg == OFS_CNT_LO) ||
                                  (awaddr_reg == OFS_CNT_HI) ||
                                  (awaddr_reg == OFS_CMPA_LO) ||
                                  (awaddr_reg == OFS_CMPA_HI) ||
                                  (awaddr_reg == OFS_CMPB_LO) ||
                                  (awaddr_reg == OFS_CMPB_HI);
  wire              unused_lane = wr_lane1;
  wire              rd_go       = ar_have_reg && !s_axi_rvalid;
  wire [7:0]        ctrl1_view  = {ctrl1_reg[7:2], 1'b0, ctrl1_reg[0]}; // R17
  logic [7:0]       rd_byte;
  logic             rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (araddr_reg) // R16
      OFS_CTRL0:   rd_byte = ctrl0_reg;
      OFS_CTRL1:   rd_byte = ctrl1_view;
      OFS_CTRL2:   rd_byte = ctrl2_reg;
      OFS_CNT_LO:  rd_byte = cnt_reg[7:0];
      OFS_CNT_HI:  rd_byte = {6'h00, cnt_reg[9:8]};
      OFS_CMPA_LO: rd_byte = cmpa_reg[7:0];
      OFS_CMPA_HI: rd_byte = {6'h00, cmpa_reg[9:8]};
      OFS_CMPB_LO: rd_byte = cmpb_reg[7:0];
      OFS_CMPB_HI: rd_byte = {6'h00, cmpb_reg[9:8]};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Control 0 next, single pulse on-bit handling
  logic [7:0]       ctrl0_next;
  always_comb begin
    ctrl0_next = ctrl0_reg;
    if (is_single && a_hit) begin
      ctrl0_next[C0_ON] = 1'b0; // R14
    end
    if (is_single && !on_bit &&
        ((cks != ETTM_CK_EXTF && ext_rise) ||
         (cks == ETTM_CK_EXTF && ext_fall))) begin
      ctrl0_next[C0_ON] = 1'b1; // R14
    end
    if (wr_c0) begin
      ctrl0_next = wb0;
    end
  end

  // Compare A next, capture beats software
  logic [9:0]       cmpa_next;
  always_comb begin
    cmpa_next = cmpa_reg;
    if (wr_al) begin
      cmpa_next[7:0] = wb0;
    end
    if (wr_ah) begin
      cmpa_next[9:8] = wb0[1:0];
    end
    if (capture) begin
      cmpa_next = cnt_reg; // R15
    end
  end

  // Timer state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl0_reg    <= CTRL0_RST;
      ctrl1_reg    <= CTRL1_RST;
      ctrl2_reg    <= CTRL2_RST;
      cmpa_reg     <= CMP_RST;
      cmpb_reg     <= CMP_RST;
      cnt_reg      <= '0;
      on_dly_reg   <= 1'b0;
      level_reg    <= 1'b0;
      div4_reg     <= '0;
      hdiv_reg     <= '0;
      ext_sync_reg <= '0;
      pin_sync_reg <= '0;
    end else if (ce) begin
      ctrl0_reg    <= ctrl0_next;
      ctrl1_reg    <= wr_c1 ? {wb0[7:2], 1'b0, wb0[0]} : ctrl1_reg;
      ctrl2_reg    <= wr_c2 ? wb0 : ctrl2_reg;
      cmpa_reg     <= cmpa_next; // R16
      cmpb_reg     <= {wr_bh ? wb1 : cmpb_reg[9:8],
                       wr_bl ? wb0 : cmpb_reg[7:0]}; // R16
      cnt_reg      <= cnt_next;
      on_dly_reg   <= on_bit;
      level_reg    <= level_next;
      div4_reg     <= div4_reg + 2'd1;
      hdiv_reg     <= high_clock_tick ? hdiv_reg + 6'd1 : hdiv_reg;
      ext_sync_reg <= {ext_sync_reg[1:0], external_clock_pin}; // R21
      pin_sync_reg <= {pin_sync_reg[0], pin_a_in};
    end
  end

  // Pin and events
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      output_pin_a    <= 1'b0;
      output_pin_a_oe <= 1'b0;
      event_a         <= 1'b0;
      event_b         <= 1'b0;
      event_p         <= 1'b0;
    end else if (ce) begin
      output_pin_a    <= level_next ^ pol; // R20
      output_pin_a_oe <= is_cmp || is_pwm;
      event_a         <= a_hit || capture; // R4
      event_b         <= b_hit;
      event_p         <= p_event; // R4
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awaddr_reg    <= '0;
      araddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      ar_have_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
    end else if (ce) begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !ar_have_reg && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg   <= s_axi_wdata;
        wstrb_reg   <= s_axi_wstrb;
        w_have_reg  <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_mapped || unused_lane && 1'b0) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_reg  <= s_axi_araddr;
        ar_have_reg <= 1'b1;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        ar_have_reg  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/ettm_assertions.sv
// Checker for the timer's register port and its period events.
// Assumes it is bound into ettm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ettm_assertions
  import ettm_pkg::*;
(
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // Events
  input  wire logic                        event_p,
  // AXI4-Lite
  input  wire logic                        s_axi_awvalid,
  input  wire logic                        s_axi_awready,
  input  wire logic                        s_axi_wvalid,
  input  wire logic                        s_axi_wready,
  input  wire logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic                        s_axi_arvalid,
  input  wire logic                        s_axi_arready,
  input  wire logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [ettm_pkg::DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]                  s_axi_rresp
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Cycles since the last period event, saturating
  logic [7:0] p_gap;
  always_ff @(posedge mclk) begin
    if (!rst_n)
      p_gap <= 8'hFF;
    else if (event_p)
      p_gap <= 8'h00;
    else if (p_gap != 8'hFF)
      p_gap <= p_gap + 8'h01;
  end
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after handshake");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not two cycles after handshake");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  a_write_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] s_axi_awready)
    else $error("write response not retired");
  a_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read response not retired");
  a_err_data_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_period_spacing: assert property (
    event_p |-> p_gap >= 8'h7F)
    else $error("period events closer than 128 cycles");
endmodule
bind ettm_top ettm_assertions chk_u (.*);
`default_nettype wire

// ### test/ettm_pins_model.sv
// Pin-side model: count clock source and capture signal on pin A.
// Assumes callers enter its tasks just after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module ettm_pins_model (
  // Clock
  input  wire logic mclk,
  // Pins
  output var  logic external_clock_pin,
  output var  logic pin_a_in
);
  initial begin
    external_clock_pin = 1'b0;
    pin_a_in = 1'b0;
  end
  // Pulses of h cycles high then h low; idles low
  task automatic pulses(input int n, input int h);
    int i;
    for (i = 0; i < 2 * n * h; i++) begin
      external_clock_pin <= (i / h) % 2 == 0;
      @(posedge mclk);
    end
  endtask
  // New level on the capture pin
  task automatic level(input logic v);
    pin_a_in <= v;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// Bench for the timer: registers, counting, compare, PWM, capture.
// Assumes the pin model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ettm_pkg::*;
  logic        mclk, rst_n, ce, high_clock_tick, time_base_tick;
  logic        external_clock_pin, pin_a_in, output_pin_a, output_pin_a_oe;
  logic        event_a, event_b, event_p, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [9:0]  c1, c2;
  logic [9:0]  cyc = 10'h000;
  int          n_mismatch, check_count;
  wire  [2:0]  evs = {event_b, event_a, event_p};
  ettm_top dut_u (.*);
  ettm_pins_model pm_u (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 10'h001;
  assign high_clock_tick = cyc[0];
  assign time_base_tick  = cyc[1:0] == 2'h0;
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tmo;
    chk("wait", 1, 0);
    summarize;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    if (i == 99) tmo;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (i == 99) tmo;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rdat);
    chk(nm, e, rdat);
  endtask
  task automatic rdcnt(output logic [9:0] c);
    logic [31:0] lo, hi;
    rd(OFS_CNT_LO, lo);
    rd(OFS_CNT_HI, hi);
    c = {hi[1:0], lo[7:0]};
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] c);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, m);
    wr(OFS_CTRL0, c);
  endtask
  task automatic wev(input int s);
    int i;
    for (i = 0; i < 40000; i++) begin
      @(posedge mclk);
      if (evs[s]) break;
    end
    if (i == 40000) tmo;
  endtask
  task automatic gap(input int s, input int e);
    int g;
    wev(s);
    for (g = 1; g < 40000; g++) begin
      @(posedge mclk);
      if (evs[s]) break;
    end
    chk("gap", e, g);
  endtask
  task automatic s_regs;
    int a;
    for (a = 0; a <= 32; a += 4) rc("reset", 8'(a), 32'h0);
    rc("unmapped", 8'h24, 32'h0);
    chk("rd_resp", RESP_SLVERR, resp);
    wr(8'h24, 8'h11);
    chk("wr_resp", RESP_SLVERR, resp);
    wr(OFS_CNT_LO, 8'hFF);
    rc("cnt_ro", OFS_CNT_LO, 32'h0);
    wr(OFS_CTRL1, 8'h02);
    rc("dir", OFS_CTRL1, 32'h0);
    wr(OFS_CTRL2, 8'hA5);
    rc("ctrl2", OFS_CTRL2, 32'hA5);
    wr(OFS_CMPB_HI, 8'h03);
    rc("cmpb_hi", OFS_CMPB_HI, 32'h3);
  endtask
  task automatic s_hold;
    logic [9:0] p;
    cfg(8'hC0, 8'h18);
    repeat (20) @(posedge mclk);
    wr(OFS_CTRL0, 8'h98);
    rdcnt(c1);
    repeat (9) @(posedge mclk);
    rdcnt(c2);
    chk("pause", c1, c2);
    chk("ran", 1'b1, c1 > 10'h00A);
    wr(OFS_CTRL0, 8'h58);
    repeat (9) @(posedge mclk);
    rdcnt(p);
    chk("rsvd", c1, p);
    wr(OFS_CTRL0, 8'h18);
    repeat (9) @(posedge mclk);
    wr(OFS_CTRL0, 8'h10);
    rdcnt(c2);
    repeat (9) @(posedge mclk);
    rdcnt(p);
    chk("off_keep", c2, p);
    chk("resumed", 1'b1, p > c1);
    wr(OFS_CTRL0, 8'h98);
    rdcnt(p);
    chk("on_clear", 10'h000, p);
  endtask
  task automatic s_gap;
    logic [7:0] c [7] = '{8'h19, 8'h1F, 8'h18, 8'h09, 8'h29, 8'h39, 8'h49};
    int e [7] = '{128, 896, 1024, 512, 4096, 16384, 512};
    int k;
    for (k = 0; k < 7; k++) begin
      cfg(8'h00, c[k]);
      gap(0, e[k]);
    end
  endtask
  task automatic s_ce;
    int g;
    cfg(8'h00, 8'h19);
    wev(0);
    ce <= 1'b0;
    repeat (50) @(posedge mclk);
    ce <= 1'b1;
    for (g = 51; g < 400; g++) begin
      @(posedge mclk);
      if (event_p) break;
    end
    chk("ce_hold", 178, g);
  endtask
  task automatic s_cmp;
    logic [7:0] m [5] = '{8'h09, 8'h19, 8'h21, 8'h39, 8'h3D};
    logic       e [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int k;
    wr(OFS_CMPA_LO, 8'h05);
    wr(OFS_CMPB_LO, 8'h03);
    wr(OFS_CMPB_HI, 8'h00);
    for (k = 0; k < 5; k++) begin
      cfg(m[k], 8'h18);
      repeat (3) @(posedge mclk);
      chk("init", m[k][3] ^ m[k][2], output_pin_a);
      chk("oe_cmp", 1'b1, output_pin_a_oe);
      wev(1);
      chk("match", e[k], output_pin_a);
      gap(1, 5);
    end
    gap(2, 5);
  endtask
  task automatic s_pwm;
    int k, n;
    for (k = 0; k < 8; k++) begin
      cfg({2'h2, 1'b0, k[0], k[1], k[2], 2'h0}, 8'h19);
      repeat (3) @(posedge mclk);
      chk("force", (k[0] ? k[1] : !k[1]) ^ k[2], output_pin_a);
      chk("oe_pwm", 1'b1, output_pin_a_oe);
    end
    cfg(8'hA8, 8'h19);
    repeat (200) @(posedge mclk);
    n = 0;
    repeat (128) begin
      @(posedge mclk);
      if (output_pin_a === 1'b1) n++;
    end
    chk("duty", 5, n);
    cfg(8'hB8, 8'h18);
    repeat (20) @(posedge mclk);
    rc("pulse_end", OFS_CTRL0, 32'h10);
    chk("pulse_pin", 1'b0, output_pin_a);
    pm_u.pulses(1, 2);
    wev(1);
    rc("pulse_ext", OFS_CTRL0, 32'h10);
    cfg(8'hC0, 8'h18);
    repeat (3) @(posedge mclk);
    chk("oe_tmr", 1'b0, output_pin_a_oe);
  endtask
  task automatic s_ext;
    cfg(8'hC0, 8'h68);
    pm_u.pulses(7, 3);
    repeat (6) @(posedge mclk);
    rdcnt(c1);
    chk("ext_rise", 10'h007, c1);
    cfg(8'hC0, 8'h78);
    pm_u.pulses(5, 1);
    repeat (6) @(posedge mclk);
    rdcnt(c1);
    chk("ext_fall", 10'h005, c1);
  endtask
  task automatic s_cap;
    int k;
    logic hit;
    for (k = 0; k < 8; k++) begin
      hit = k[1:0] == 2'h2 || k[1:0] == {1'b0, !k[2]};
      wr(OFS_CTRL0, 8'h00);
      pm_u.level(!k[2]);
      wr(OFS_CMPA_LO, 8'h00);
      wr(OFS_CTRL1, {2'h1, k[1:0], 4'h0});
      wr(OFS_CTRL0, 8'h68);
      pm_u.pulses(9, 2);
      repeat (8) @(posedge mclk);
      chk("oe_cap", 1'b0, output_pin_a_oe);
      pm_u.level(k[2]);
      repeat (8) @(posedge mclk);
      rc("capture", OFS_CMPA_LO, hit ? 32'h9 : 32'h0);
    end
  endtask
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    s_regs;
    s_hold;
    s_gap;
    s_ce;
    s_cmp;
    s_pwm;
    s_ext;
    s_cap;
    summarize;
  end
endmodule
`default_nettype wire
